// *** include/olc_defines.svh ***
// register offsets, field positions, reset values for the output loop control bank
`ifndef OLC_DEFINES_SVH
`define OLC_DEFINES_SVH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define OLC_ADDR_ZERO_RES 12'h01d
`define OLC_ADDR_PUMP_CUR 12'h0f0
`define OLC_ADDR_FB_DIV 12'h0f1
`define OLC_ADDR_CTRL 12'h0f2
`define OLC_ADDR_VCO 12'h0f3

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define OLC_CTRL_LD_PD 7
`define OLC_CTRL_DBL_EN 5
`define OLC_CTRL_ABL_OVR 4
`define OLC_CTRL_ABL_HI 3
`define OLC_CTRL_ABL_LO 2
`define OLC_CTRL_CPM_HI 1
`define OLC_CTRL_CPM_LO 0
`define OLC_FB_A_HI 7
`define OLC_FB_A_LO 6
`define OLC_FB_B_HI 5
`define OLC_FB_B_LO 0
`define OLC_VCO_FREL 4
`define OLC_VCO_MID 2
`define OLC_VCO_CAL 1

// ------------------------------------------------------------
// reset values and fixed codes
// ------------------------------------------------------------
`define OLC_RST_ZERO_RES 4'h0
`define OLC_RST_PUMP_CUR 8'h00
`define OLC_RST_FB_DIV 8'h00
`define OLC_RST_CTRL 8'h03
`define OLC_RST_VCO 8'h00
`define OLC_VCO_WR_MASK 8'h1e
`define OLC_ABL_AUTO 2'h2
`define OLC_ABL_FIRST 2'h0
`define OLC_ZRES_EXT 4'h8

`endif

// *** include/olc_pkg.sv ***
// types shared by the output loop control bank
package olc_pkg;
    // charge pump mode codes
    typedef enum logic [1:0] {
        OLC_CPM_TRISTATE = 2'h0,
        OLC_CPM_PUMP_UP = 2'h1,
        OLC_CPM_PUMP_DOWN = 2'h2,
        OLC_CPM_NORMAL = 2'h3
    } olc_cp_mode_t;
    // antibacklash width codes
    typedef enum logic [1:0] {
        OLC_ABL_MIN = 2'h0,
        OLC_ABL_LOW = 2'h1,
        OLC_ABL_HIGH = 2'h2,
        OLC_ABL_MAX = 2'h3
    } olc_abl_width_t;
endpackage : olc_pkg

// *** verilog/olc_regs.sv ***
// output loop control register bank with decoded loop settings
//
// Notes on behaviour
// - 4-bit code selects input loop zero resistance
// - 8-bit output loop charge pump magnitude
// - divider ratio is four times main plus swallow
// - control bit 7 powers down lock detector
// - control bit 5 enables reference doubler
// - override clear forces antibacklash to high
// - width field effective only while override set
// - first override set makes width minimum
// - charge pump mode field, normal by default
// - hold distribution sync until loop locks
// - force bit releases sync regardless of lock
// - oscillator bit 2 forces midscale control voltage
// - calibration bit sticky, zero resets calibration
`include "olc_defines.svh"

module olc_regs #(
    parameter int ADDR_W = 12
) (
    input wire logic core_clk_i,                       // register clock
    input wire logic rst_n_i,                          // async reset, active low
    input wire logic [ADDR_W-1:0] addr_i,              // register address from serial port
    input wire logic wr_en_i,                          // one-cycle write strobe
    input wire logic [7:0] wr_data_i,                  // write data
    input wire logic rd_en_i,                          // one-cycle read strobe
    input wire logic loop_locked_i,                    // output loop lock report
    output logic [7:0] rd_data_o,                      // read data
    output logic rd_valid_o,                           // read data valid pulse
    output logic [3:0] loop_zero_resistance_o,         // zero resistor code
    output logic zero_res_ext_o,                       // external zero resistor selected
    output logic [7:0] pump_current_o,                 // charge pump magnitude
    output logic [1:0] fb_swallow_o,                   // swallow count
    output logic [5:0] fb_main_o,                      // main count
    output logic [7:0] fb_ratio_o,                     // resulting division ratio
    output logic lock_det_pd_o,                        // lock detector power-down
    output logic ref_doubler_en_o,                     // reference doubler enable
    output olc_pkg::olc_abl_width_t abl_width_o,       // effective antibacklash width
    output olc_pkg::olc_cp_mode_t cp_mode_o,           // charge pump mode
    output logic dist_sync_hold_o,                     // distribution held in sync
    output logic vco_midscale_o,                       // force vco to midscale
    output logic vco_cal_o,                            // calibration run level
    output logic vco_cal_start_o                       // one-cycle calibration start pulse
);
    import olc_pkg::*;

    // ------------------------------------------------------------
    // storage and decode
    // ------------------------------------------------------------
    logic [3:0] zres_q;        // zero resistor code
    logic [7:0] pump_q;        // pump magnitude
    logic [7:0] fb_q;          // feedback divider word
    logic [7:0] ctrl_q;        // output loop control word
    logic [7:0] vco_q;         // oscillator control word
    logic [7:0] ratio_q;       // registered division ratio
    logic [1:0] abl_q;         // registered effective width
    logic sync_hold_q;         // registered sync hold
    logic cal_start_q;         // calibration start pulse
    logic zres_ext_q;          // external resistor decode
    logic [7:0] rd_q;          // read data
    logic rd_vld_q;            // read valid
    logic wr_zres;             // write hits zero resistor register
    logic wr_pump;             // write hits pump register
    logic wr_fb;               // write hits divider register
    logic wr_ctrl;             // write hits control register
    logic wr_vco;              // write hits oscillator register

    assign wr_zres = wr_en_i && (addr_i == `OLC_ADDR_ZERO_RES);
    assign wr_pump = wr_en_i && (addr_i == `OLC_ADDR_PUMP_CUR);
    assign wr_fb = wr_en_i && (addr_i == `OLC_ADDR_FB_DIV);
    assign wr_ctrl = wr_en_i && (addr_i == `OLC_ADDR_CTRL);
    assign wr_vco = wr_en_i && (addr_i == `OLC_ADDR_VCO);

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    // zero resistor code, upper nibble not stored
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            zres_q <= `OLC_RST_ZERO_RES;
        end else if (wr_zres) begin
            zres_q <= wr_data_i[3:0];
        end
    end

    // pump magnitude, full byte
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pump_q <= `OLC_RST_PUMP_CUR;
        end else if (wr_pump) begin
            pump_q <= wr_data_i;
        end
    end

    // divider word, stored as written; limits are left to software
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fb_q <= `OLC_RST_FB_DIV;
        end else if (wr_fb) begin
            fb_q <= wr_data_i;
        end
    end

    // control word; width snaps to minimum when override first goes high
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_q <= `OLC_RST_CTRL;
        end else if (wr_ctrl) begin
            ctrl_q <= wr_data_i;
            if (wr_data_i[`OLC_CTRL_ABL_OVR] && !ctrl_q[`OLC_CTRL_ABL_OVR]) begin
                // first override set: field defaults to minimum
                ctrl_q[`OLC_CTRL_ABL_HI:`OLC_CTRL_ABL_LO] <= `OLC_ABL_FIRST;
            end
        end
    end

    // oscillator control, reserved bits 7:5 and 0 dropped
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            vco_q <= `OLC_RST_VCO;
        end else if (wr_vco) begin
            vco_q <= wr_data_i & `OLC_VCO_WR_MASK;
        end
    end

    // ------------------------------------------------------------
    // derived settings
    // ------------------------------------------------------------
    // ratio and external resistor decode
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ratio_q <= 8'h00;
            zres_ext_q <= 1'b0;
        end else begin
            ratio_q <= {fb_q[`OLC_FB_B_HI:`OLC_FB_B_LO], 2'h0} + {6'h00, fb_q[`OLC_FB_A_HI:`OLC_FB_A_LO]};
            zres_ext_q <= (zres_q == `OLC_ZRES_EXT);
        end
    end

    // effective antibacklash width
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            abl_q <= `OLC_ABL_AUTO;
        end else if (ctrl_q[`OLC_CTRL_ABL_OVR]) begin
            abl_q <= ctrl_q[`OLC_CTRL_ABL_HI:`OLC_CTRL_ABL_LO];
        end else begin
            abl_q <= `OLC_ABL_AUTO;
        end
    end

    // distribution sync hold until lock or forced release
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync_hold_q <= 1'b1;
        end else if (vco_q[`OLC_VCO_FREL]) begin
            sync_hold_q <= 1'b0;
        end else begin
            sync_hold_q <= !loop_locked_i;
        end
    end

    // start pulse on a zero-to-one write of the calibration bit
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cal_start_q <= 1'b0;
        end else begin
            cal_start_q <= wr_vco && wr_data_i[`OLC_VCO_CAL] && !vco_q[`OLC_VCO_CAL];
        end
    end

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    // registered read, unmapped addresses return zero
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_q <= 8'h00;
            rd_vld_q <= 1'b0;
        end else begin
            rd_vld_q <= rd_en_i;
            if (rd_en_i) begin
                unique case (addr_i)
                    `OLC_ADDR_ZERO_RES: rd_q <= {4'h0, zres_q};
                    `OLC_ADDR_PUMP_CUR: rd_q <= pump_q;
                    `OLC_ADDR_FB_DIV: rd_q <= fb_q;
                    `OLC_ADDR_CTRL: rd_q <= ctrl_q;
                    `OLC_ADDR_VCO: rd_q <= vco_q;
                    default: rd_q <= 8'h00;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign rd_data_o = rd_q;
    assign rd_valid_o = rd_vld_q;
    assign loop_zero_resistance_o = zres_q;
    assign zero_res_ext_o = zres_ext_q;
    assign pump_current_o = pump_q;
    assign fb_swallow_o = fb_q[`OLC_FB_A_HI:`OLC_FB_A_LO];
    assign fb_main_o = fb_q[`OLC_FB_B_HI:`OLC_FB_B_LO];
    assign fb_ratio_o = ratio_q;
    assign lock_det_pd_o = ctrl_q[`OLC_CTRL_LD_PD];
    assign ref_doubler_en_o = ctrl_q[`OLC_CTRL_DBL_EN];
    assign abl_width_o = olc_abl_width_t'(abl_q);
    assign cp_mode_o = olc_cp_mode_t'(ctrl_q[`OLC_CTRL_CPM_HI:`OLC_CTRL_CPM_LO]);
    assign dist_sync_hold_o = sync_hold_q;
    assign vco_midscale_o = vco_q[`OLC_VCO_MID];
    assign vco_cal_o = vco_q[`OLC_VCO_CAL];
    assign vco_cal_start_o = cal_start_q;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_cal_rise;
        wr_vco && wr_data_i[`OLC_VCO_CAL] && !vco_q[`OLC_VCO_CAL];
    endsequence
    sequence s_first_ovr;
        wr_ctrl && wr_data_i[`OLC_CTRL_ABL_OVR] && !ctrl_q[`OLC_CTRL_ABL_OVR];
    endsequence

    a_ratio_formula: assert property (wr_fb |=> ##1 fb_ratio_o == 8'(4 * $past(wr_data_i[5:0], 2) + $past(wr_data_i[7:6], 2)))
        else $error("division ratio wrong");
    a_abl_auto_high: assert property (!ctrl_q[`OLC_CTRL_ABL_OVR] |=> abl_width_o == OLC_ABL_HIGH)
        else $error("auto width not high");
    a_abl_override_use: assert property (ctrl_q[`OLC_CTRL_ABL_OVR] |=> abl_width_o == $past(ctrl_q[3:2]))
        else $error("override width not used");
    a_abl_first_min: assert property (s_first_ovr |=> ctrl_q[3:2] == 2'h0 ##1 abl_width_o == OLC_ABL_MIN)
        else $error("first override width not minimum");
    a_sync_hold_lock: assert property (!vco_q[`OLC_VCO_FREL] |=> dist_sync_hold_o == !$past(loop_locked_i))
        else $error("sync hold does not follow lock");
    a_sync_force_release: assert property (vco_q[`OLC_VCO_FREL] |=> !dist_sync_hold_o)
        else $error("forced release ignored");
    a_cal_sticky_bit: assert property (vco_cal_o && !wr_vco |=> vco_cal_o)
        else $error("calibration bit cleared itself");
    a_cal_start_pulse: assert property (s_cal_rise |=> vco_cal_start_o && vco_cal_o ##1 !vco_cal_start_o)
        else $error("calibration start pulse wrong");
    a_vco_read_rsvd: assert property (rd_en_i && addr_i == `OLC_ADDR_VCO |=> rd_valid_o && rd_data_o[7:5] == 3'h0 && !rd_data_o[0])
        else $error("oscillator reserved bits read nonzero");
    a_ctrl_read_back: assert property (rd_en_i && addr_i == `OLC_ADDR_CTRL |=> rd_data_o == $past(ctrl_q))
        else $error("control read mismatch");
    a_zres_ext_sel: assert property (1'b1 |=> zero_res_ext_o == ($past(zres_q) == `OLC_ZRES_EXT))
        else $error("external resistor not flagged");
    a_cpm_write_take: assert property (wr_ctrl |=> cp_mode_o == $past(wr_data_i[1:0]) && lock_det_pd_o == $past(wr_data_i[7]))
        else $error("control write not taken");
endmodule : olc_regs

// *** tb/test_olc_regs.sv ***
// self-checking testbench for the output loop control register bank
`include "olc_defines.svh"
module test_olc_regs;
    timeunit 1ns;
    timeprecision 1ps;
    import olc_pkg::*;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic core_clk_i;            // register clock
    logic rst_n_i;               // async reset, active low
    logic [11:0] addr_i;         // register address
    logic wr_en_i;               // write strobe
    logic [7:0] wr_data_i;       // write data
    logic rd_en_i;               // read strobe
    logic loop_locked_i;         // lock report
    logic [7:0] rd_data_o;
    logic rd_valid_o;
    logic [3:0] loop_zero_resistance_o;
    logic zero_res_ext_o;
    logic [7:0] pump_current_o;
    logic [1:0] fb_swallow_o;
    logic [5:0] fb_main_o;
    logic [7:0] fb_ratio_o;
    logic lock_det_pd_o;
    logic ref_doubler_en_o;
    olc_abl_width_t abl_width_o;
    olc_cp_mode_t cp_mode_o;
    logic dist_sync_hold_o;
    logic vco_midscale_o;
    logic vco_cal_o;
    logic vco_cal_start_o;
    int n_mismatch;              // mismatches seen
    int compares;                // comparisons made
    int n_pulse;                 // calibration start pulses seen
    int p0;                      // pulse count snapshot
    // ----------------------------------------
    // design under test
    // ----------------------------------------
    olc_regs i_dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wr_en_i(wr_en_i),
        .wr_data_i(wr_data_i), .rd_en_i(rd_en_i), .loop_locked_i(loop_locked_i), .rd_data_o(rd_data_o),
        .rd_valid_o(rd_valid_o), .loop_zero_resistance_o(loop_zero_resistance_o),
        .zero_res_ext_o(zero_res_ext_o), .pump_current_o(pump_current_o), .fb_swallow_o(fb_swallow_o),
        .fb_main_o(fb_main_o), .fb_ratio_o(fb_ratio_o), .lock_det_pd_o(lock_det_pd_o),
        .ref_doubler_en_o(ref_doubler_en_o), .abl_width_o(abl_width_o), .cp_mode_o(cp_mode_o),
        .dist_sync_hold_o(dist_sync_hold_o), .vco_midscale_o(vco_midscale_o), .vco_cal_o(vco_cal_o),
        .vco_cal_start_o(vco_cal_start_o));
    // clock, 100 MHz
    initial begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end
    // counts one-cycle calibration start pulses
    always @(posedge core_clk_i) begin
        if (vco_cal_start_o === 1'b1) n_pulse++;
    end
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic cmp(input string name, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : cmp
    // waits n edges, then lets their updates land
    task automatic step(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask : step
    // verdict and end of run
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : complete_run
    // one write strobe, then time for derived outputs to settle
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        addr_i = a;
        wr_data_i = d;
        wr_en_i = 1'b1;
        step(1);
        wr_en_i = 1'b0;
        step(2);
    endtask : wr
    // one read strobe, bounded wait for valid, compare data
    task automatic rd(input logic [11:0] a, input logic [7:0] exp, input string name);
        int i;
        addr_i = a;
        rd_en_i = 1'b1;
        step(1);
        rd_en_i = 1'b0;
        for (i = 0; i < 4 && rd_valid_o !== 1'b1; i++) step(1);
        if (i == 4) begin
            // timeout counts as a mismatch and goes straight to the verdict
            n_mismatch++;
            $display("MISMATCH rd_valid_o expected 1 seen timeout");
            complete_run();
        end else begin
            cmp(name, exp, rd_data_o);
            step(1);
        end
    endtask : rd
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        rst_n_i = 1'b0;
        addr_i = 12'h000;
        wr_en_i = 1'b0;
        wr_data_i = 8'h00;
        rd_en_i = 1'b0;
        loop_locked_i = 1'b0;
        step(5);
        rst_n_i = 1'b1;
        step(1);
        // reset values and defaults
        cmp("cp_mode", 8'h03, cp_mode_o);
        cmp("abl_auto", 8'h02, abl_width_o);
        cmp("sync_hold", 8'h01, dist_sync_hold_o);
        rd(`OLC_ADDR_CTRL, 8'h03, "ctrl_rst");
        rd(`OLC_ADDR_VCO, 8'h00, "vco_rst");
        $display("test reset done");
        // zero resistor codes 0 to 8, then reserved bits
        for (int c = 0; c < 9; c++) begin
            wr(`OLC_ADDR_ZERO_RES, 8'(c));
            cmp("zres", 8'(c), loop_zero_resistance_o);
            cmp("zres_ext", (c == 8) ? 8'h01 : 8'h00, zero_res_ext_o);
        end
        wr(`OLC_ADDR_ZERO_RES, 8'hf8);
        rd(`OLC_ADDR_ZERO_RES, 8'h08, "zres_rd");
        $display("test zero resistor done");
        // pump current full byte
        wr(`OLC_ADDR_PUMP_CUR, 8'ha5);
        cmp("pump", 8'ha5, pump_current_o);
        rd(`OLC_ADDR_PUMP_CUR, 8'ha5, "pump_rd");
        // divider limits: ratios 17, 26, 255
        // swallow counts stay inside the limits for each main count
        wr(`OLC_ADDR_FB_DIV, {2'd1, 6'd4});
        cmp("ratio17", 8'd17, fb_ratio_o);
        wr(`OLC_ADDR_FB_DIV, {2'd2, 6'd6});
        cmp("ratio26", 8'd26, fb_ratio_o);
        wr(`OLC_ADDR_FB_DIV, {2'd3, 6'd63});
        cmp("ratio255", 8'd255, fb_ratio_o);
        cmp("swallow", 8'd3, fb_swallow_o);
        cmp("main", 8'd63, fb_main_o);
        $display("test pump and divider done");
        // charge pump modes, doubler and lock detector power-down
        for (int m = 0; m < 4; m++) begin
            // control writes keep reserved bit 6 at zero
            wr(`OLC_ADDR_CTRL, {1'b1, 2'b01, 3'b000, 2'(m)});
            cmp("cp_mode", 8'(m), cp_mode_o);
            cmp("ld_pd", 8'h01, lock_det_pd_o);
            cmp("dbl", 8'h01, ref_doubler_en_o);
        end
        wr(`OLC_ADDR_CTRL, 8'h03);
        cmp("ld_pd_off", 8'h00, lock_det_pd_o);
        cmp("dbl_off", 8'h00, ref_doubler_en_o);
        // antibacklash: first override forces minimum, then widths apply
        wr(`OLC_ADDR_CTRL, 8'h1f);
        cmp("abl_first", 8'h00, abl_width_o);
        rd(`OLC_ADDR_CTRL, 8'h13, "ctrl_first");
        wr(`OLC_ADDR_CTRL, 8'h1f);
        cmp("abl_max", 8'h03, abl_width_o);
        wr(`OLC_ADDR_CTRL, 8'h17);
        cmp("abl_low", 8'h01, abl_width_o);
        wr(`OLC_ADDR_CTRL, 8'h0f);
        cmp("abl_auto", 8'h02, abl_width_o);
        $display("test control done");
        // distribution sync follows lock until force release
        loop_locked_i = 1'b1;
        step(2);
        cmp("sync_locked", 8'h00, dist_sync_hold_o);
        loop_locked_i = 1'b0;
        step(2);
        cmp("sync_unlocked", 8'h01, dist_sync_hold_o);
        wr(`OLC_ADDR_VCO, 8'h10);
        cmp("sync_forced", 8'h00, dist_sync_hold_o);
        $display("test sync done");
        // oscillator bits, write mask and sticky calibration
        p0 = n_pulse;
        // reserved bits 7:5 and 0 set to test the mask, bit 3 kept at zero
        wr(`OLC_ADDR_VCO, 8'hf7);
        rd(`OLC_ADDR_VCO, 8'h16, "vco_mask");
        cmp("midscale", 8'h01, vco_midscale_o);
        cmp("cal_lvl", 8'h01, vco_cal_o);
        cmp("cal_pulse", 8'h01, 8'(n_pulse - p0));
        step(4);
        cmp("cal_sticky", 8'h01, vco_cal_o);
        wr(`OLC_ADDR_VCO, 8'h02);
        cmp("midscale_off", 8'h00, vco_midscale_o);
        cmp("cal_again", 8'h01, 8'(n_pulse - p0));
        wr(`OLC_ADDR_VCO, 8'h00);
        cmp("cal_reset", 8'h00, vco_cal_o);
        wr(`OLC_ADDR_VCO, 8'h02);
        cmp("cal_restart", 8'h02, 8'(n_pulse - p0));
        $display("test oscillator done");
        // unmapped addresses change nothing and read zero
        wr(12'h100, 8'hff);
        rd(12'h100, 8'h00, "unmapped");
        rd(12'h0f4, 8'h00, "unmapped_next");
        rd(`OLC_ADDR_PUMP_CUR, 8'ha5, "pump_kept");
        $display("test unmapped done");
        complete_run();
    end
endmodule : test_olc_regs
